// ===== core/smp_pkg.sv
`default_nettype none
package smp_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_BANK_CFG0 = 8'h00;
    localparam logic [7:0] OFS_ADDR = 8'h20;
    localparam logic [7:0] OFS_WDATA = 8'h24;
    localparam logic [7:0] OFS_CMD = 8'h28;
    localparam logic [7:0] OFS_RDATA = 8'h2C;
    localparam logic [7:0] OFS_STATUS = 8'h30;
    // ------------------------------------------------------------
    // bank configuration fields
    // ------------------------------------------------------------
    localparam int CFG_CS_POL = 0;
    localparam int CFG_WAIT_EN = 1;
    localparam int CFG_WAIT_POL = 2;
    localparam int CFG_BURST = 3;
    localparam int CFG_WIDTH_LO = 4;
    localparam int CFG_LANE_POL = 6;
    localparam int CFG_WS_LO = 8;
    localparam int CFG_WSB_LO = 16;
    localparam logic [31:0] CFG_RST = 32'h0000_0000;
    localparam logic [31:0] CFG_MASK = 32'h001F_1F7F;
    // ------------------------------------------------------------
    // command and status fields
    // ------------------------------------------------------------
    localparam int CMD_BANK_LO = 0;
    localparam int CMD_WRITE = 3;
    localparam int CMD_LANE_LO = 4;
    localparam int CMD_BEATS_LO = 8;
    localparam int ST_BUSY = 0;
    localparam int ST_CANCELLED = 1;
    localparam int ST_FB_SEEN = 2;
    localparam int ST_BIG_END = 3;
    // ------------------------------------------------------------
    // encodings and counts
    // ------------------------------------------------------------
    localparam logic [1:0] WIDTH_8 = 2'h0;
    localparam logic [1:0] WIDTH_16 = 2'h1;
    localparam logic [1:0] WIDTH_32 = 2'h2;
    localparam logic [1:0] STRAP_LOAD_CNT = 2'h2;
    localparam logic [25:0] ADDR_RST = 26'h0000000;
    localparam logic [31:0] DATA_RST = 32'h0000_0000;
    localparam logic [1:0] SYNC_LAT = 2'h2;
    typedef enum {smp_idle, smp_addr, smp_access, smp_end} smp_state_e;
endpackage
`default_nettype wire

// ===== core/smp_pad_if.sv
`default_nettype none
// Notes on behaviour
// - bank 7 lane-select polarity bit 6 resets from the polarity strap pin
// - cancel_wait high ends an externally waited transfer instead of waiting on
// - two strap pins give boot bank width: 00 8-bit, 01 16, 10 32
// - ext_wait holds a transfer; polarity per bank, active low by default
// - one chip select per bank 0..7, active low by default
// - four active-low data drive enables, one per byte lane
// - four byte lane selects, polarity per bank, active low by default, bit 3 is data 31:24
// - one shared active-low output enable, asserted on reads
// - one shared active-low write enable, asserted on writes
// - 26-bit external address bus
// - address_valid marks the stable address cycle of synchronous bursts
// - burst_address_advance pulses to step the memory's burst counter
// - burst_wait_n low stalls a synchronous burst
// - separate 32-bit read and write data buses
// - four clock outputs for synchronous memories
// - feedback clock from memories is only watched for edges, reported as a status bit
// - big_endian_select: 0 little, 1 big endian
module smp_pad_if
    import smp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic boot_lane_select_polarity,
    input wire logic [1:0] boot_bank_width,
    input wire logic mem_clk,
    input wire logic [1:0] mem_clock_ratio,
    input wire logic big_endian_select,
    input wire logic ext_wait,
    input wire logic burst_wait_n,
    input wire logic cancel_wait,
    input wire logic mem_feedback_clock,
    input wire logic [31:0] mem_read_data,
    output logic [31:0] mem_write_data,
    output logic [25:0] mem_address,
    output logic [7:0] bank_select_n,
    output logic [3:0] byte_lane_select_n,
    output logic [3:0] data_lane_drive_n,
    output logic mem_output_enable_n,
    output logic mem_write_enable_n,
    output logic address_valid,
    output logic burst_address_advance,
    output logic [3:0] mem_clock_out
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [3:0] width_lanes(input logic [1:0] w);
        case (w)
            WIDTH_8: width_lanes = 4'h1;
            WIDTH_16: width_lanes = 4'h3;
            default: width_lanes = 4'hF;
        endcase
    endfunction

    function automatic logic [31:0] swap_bytes(input logic [31:0] d, input logic en);
        swap_bytes = en ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
    endfunction

    // ------------------------------------------------------------
    // apb domain: strap capture
    // ------------------------------------------------------------
    logic [2:0] strap_s1;
    logic [2:0] strap_s2;
    logic [1:0] strap_cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_s1 <= 3'h0;
            strap_s2 <= 3'h0;
            strap_cnt <= 2'h0;
        end else begin
            strap_s1 <= {boot_lane_select_polarity, boot_bank_width};
            strap_s2 <= strap_s1;
            if (strap_cnt != STRAP_LOAD_CNT + 2'h1) begin
                strap_cnt <= strap_cnt + 2'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // apb domain: registers
    // ------------------------------------------------------------
    logic [31:0] bank_cfg [8];
    logic [25:0] cmd_addr;
    logic [31:0] cmd_wdata;
    logic [15:0] cmd_word;
    logic [31:0] cmd_cfg;
    logic [31:0] rdata;
    logic busy;
    logic cancelled;
    logic start_tog;
    logic [2:0] done_s1;
    logic [2:0] done_s2;
    logic done_seen;
    logic done_evt;
    logic wr_acc;
    logic rd_acc;
    logic mapped;
    logic [31:0] lk_rdata;
    logic lk_cancelled;
    logic lk_done_tog;
    logic lk_fb_seen;
    logic lk_big;

    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign mapped = (paddr[1:0] == 2'h0) && (paddr <= OFS_STATUS);
    assign done_evt = done_s2[0] != done_seen;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_cfg
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    bank_cfg[gi] <= CFG_RST;
                end else if (gi == 7 && strap_cnt == STRAP_LOAD_CNT) begin
                    bank_cfg[gi][CFG_LANE_POL] <= strap_s2[2];
                    bank_cfg[gi][CFG_WIDTH_LO +: 2] <= strap_s2[1:0];
                end else if (wr_acc && paddr[7:5] == 3'h0 && paddr[4:2] == 3'(gi)) begin
                    bank_cfg[gi] <= pwdata & CFG_MASK;
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_addr <= ADDR_RST;
            cmd_wdata <= DATA_RST;
        end else if (wr_acc && !busy) begin
            if (paddr == OFS_ADDR) begin
                cmd_addr <= pwdata[25:0];
            end
            if (paddr == OFS_WDATA) begin
                cmd_wdata <= pwdata;
            end
        end
    end

    // command start and completion handshake
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_word <= 16'h0000;
            cmd_cfg <= CFG_RST;
            busy <= 1'b0;
            cancelled <= 1'b0;
            start_tog <= 1'b0;
            rdata <= DATA_RST;
            done_s1 <= 3'h0;
            done_s2 <= 3'h0;
            done_seen <= 1'b0;
        end else begin
            done_s1 <= {lk_big, lk_fb_seen, lk_done_tog};
            done_s2 <= done_s1;
            done_seen <= done_s2[0];
            if (wr_acc && paddr == OFS_CMD && !busy) begin
                cmd_word <= pwdata[15:0];
                cmd_cfg <= bank_cfg[pwdata[CMD_BANK_LO +: 3]];
                busy <= 1'b1;
                cancelled <= 1'b0;
                start_tog <= ~start_tog;
            end else if (done_evt) begin
                busy <= 1'b0;
                rdata <= lk_rdata;
                cancelled <= lk_cancelled;
            end
        end
    end

    // apb read mux
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= DATA_RST;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= DATA_RST;
            if (psel && !penable && !pwrite && mapped) begin
                if (paddr[7:5] == 3'h0) begin
                    prdata <= bank_cfg[paddr[4:2]];
                end else begin
                    case (paddr)
                        OFS_ADDR: prdata <= {6'h00, cmd_addr};
                        OFS_WDATA: prdata <= cmd_wdata;
                        OFS_CMD: prdata <= {16'h0000, cmd_word};
                        OFS_RDATA: prdata <= rdata;
                        OFS_STATUS: prdata <= {28'h0000000, done_s2[2:1],
                            cancelled, busy};
                        default: prdata <= DATA_RST;
                    endcase
                end
            end
        end
    end

    // ------------------------------------------------------------
    // link domain: input synchronisers
    // ------------------------------------------------------------
    logic lrst_s1;
    logic lrst_n;
    logic [39:0] in_s1;
    logic [39:0] in_s2;
    logic start_s1;
    logic start_s2;
    logic start_seen;
    logic fb_prev;
    logic [31:0] rd_s;
    logic [1:0] ratio_s;
    logic big_s;
    logic wait_s;
    logic bwait_n_s;
    logic cancel_s;
    logic fb_s;

    always_ff @(posedge mem_clk or negedge presetn) begin
        if (!presetn) begin
            lrst_s1 <= 1'b0;
            lrst_n <= 1'b0;
        end else begin
            lrst_s1 <= 1'b1;
            lrst_n <= lrst_s1;
        end
    end

    always_ff @(posedge mem_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            in_s1 <= 40'h00_0000_0008;
            in_s2 <= 40'h00_0000_0008;
            start_s1 <= 1'b0;
            start_s2 <= 1'b0;
            start_seen <= 1'b0;
            fb_prev <= 1'b0;
        end else begin
            in_s1 <= {mem_read_data, mem_clock_ratio, big_endian_select, ext_wait,
                burst_wait_n, cancel_wait, mem_feedback_clock, 1'b0};
            in_s2 <= in_s1;
            start_s1 <= start_tog;
            start_s2 <= start_s1;
            start_seen <= start_s2;
            fb_prev <= fb_s;
        end
    end
    assign {rd_s, ratio_s, big_s, wait_s, bwait_n_s, cancel_s, fb_s} = in_s2[39:1];

    // feedback clock activity and endian status
    always_ff @(posedge mem_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            lk_fb_seen <= 1'b0;
            lk_big <= 1'b0;
        end else begin
            lk_big <= big_s;
            if (fb_s && !fb_prev) begin
                lk_fb_seen <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // link domain: memory clock divider
    // ------------------------------------------------------------
    logic [1:0] div_cnt;
    always_ff @(posedge mem_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            div_cnt <= 2'h0;
            mem_clock_out <= 4'h0;
        end else if (div_cnt >= ratio_s || ratio_s == 2'h3) begin
            div_cnt <= 2'h0;
            mem_clock_out <= ~mem_clock_out;
        end else begin
            div_cnt <= div_cnt + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // link domain: access engine
    // ------------------------------------------------------------
    smp_state_e state;
    logic [31:0] cfg_l;
    logic write_l;
    logic [3:0] lanes_l;
    logic [3:0] beats_l;
    logic [4:0] wcnt;
    logic [7:0] cs_on;
    logic wait_active;
    logic burst_l;
    logic [1:0] lat_cnt;

    assign burst_l = cfg_l[CFG_BURST];
    assign wait_active = cfg_l[CFG_WAIT_EN] && (wait_s == cfg_l[CFG_WAIT_POL]);
    assign cs_on = 8'h01 << cmd_word[CMD_BANK_LO +: 3];

    always_ff @(posedge mem_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            state <= smp_idle;
            cfg_l <= CFG_RST;
            write_l <= 1'b0;
            lanes_l <= 4'h0;
            beats_l <= 4'h0;
            wcnt <= 5'h00;
            lat_cnt <= 2'h0;
            lk_rdata <= DATA_RST;
            lk_cancelled <= 1'b0;
            lk_done_tog <= 1'b0;
            mem_address <= ADDR_RST;
            mem_write_data <= DATA_RST;
            bank_select_n <= 8'hFF;
            byte_lane_select_n <= 4'hF;
            data_lane_drive_n <= 4'hF;
            mem_output_enable_n <= 1'b1;
            mem_write_enable_n <= 1'b1;
            address_valid <= 1'b0;
            burst_address_advance <= 1'b0;
        end else begin
            burst_address_advance <= 1'b0;
            case (state)
                smp_idle: begin
                    if (start_s2 != start_seen) begin
                        cfg_l <= cmd_cfg;
                        write_l <= cmd_word[CMD_WRITE];
                        lanes_l <= cmd_word[CMD_LANE_LO +: 4] &
                            width_lanes(cmd_cfg[CFG_WIDTH_LO +: 2]);
                        beats_l <= cmd_cfg[CFG_BURST] ? cmd_word[CMD_BEATS_LO +: 4] : 4'h0;
                        wcnt <= cmd_cfg[CFG_WS_LO +: 5];
                        lat_cnt <= SYNC_LAT;
                        lk_cancelled <= 1'b0;
                        mem_address <= cmd_addr;
                        mem_write_data <= swap_bytes(cmd_wdata, big_s);
                        bank_select_n <= cmd_cfg[CFG_CS_POL] ? cs_on : ~cs_on;
                        address_valid <= cmd_cfg[CFG_BURST];
                        state <= smp_addr;
                    end
                end
                smp_addr: begin
                    address_valid <= 1'b0;
                    mem_output_enable_n <= write_l;
                    mem_write_enable_n <= !write_l;
                    byte_lane_select_n <= cfg_l[CFG_LANE_POL] ? lanes_l : ~lanes_l;
                    data_lane_drive_n <= write_l ? ~lanes_l : 4'hF;
                    state <= smp_access;
                end
                smp_access: begin
                    if (lat_cnt != 2'h0) begin
                        lat_cnt <= lat_cnt - 2'h1;
                    end else if (wcnt != 5'h00) begin
                        wcnt <= wcnt - 5'h01;
                    end else if (wait_active && cancel_s) begin
                        lk_cancelled <= 1'b1;
                        state <= smp_end;
                    end else if (wait_active) begin
                        state <= smp_access;
                    end else if (burst_l && !bwait_n_s) begin
                        state <= smp_access;
                    end else begin
                        if (!write_l) begin
                            lk_rdata <= swap_bytes(rd_s, big_s);
                        end
                        if (beats_l != 4'h0) begin
                            beats_l <= beats_l - 4'h1;
                            wcnt <= cfg_l[CFG_WSB_LO +: 5];
                            lat_cnt <= SYNC_LAT;
                            burst_address_advance <= 1'b1;
                        end else begin
                            state <= smp_end;
                        end
                    end
                end
                smp_end: begin
                    bank_select_n <= 8'hFF;
                    byte_lane_select_n <= cfg_l[CFG_LANE_POL] ? 4'h0 : 4'hF;
                    data_lane_drive_n <= 4'hF;
                    mem_output_enable_n <= 1'b1;
                    mem_write_enable_n <= 1'b1;
                    lk_done_tog <= ~lk_done_tog;
                    state <= smp_idle;
                end
                default: state <= smp_idle;
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== verif/smp_mem_model.sv
`default_nettype none
module smp_mem_model (
    input wire logic mem_clk,
    input wire logic stall,
    input wire logic [25:0] mem_address,
    input wire logic [7:0] bank_select_n,
    input wire logic [3:0] byte_lane_select_n,
    input wire logic mem_output_enable_n,
    input wire logic mem_write_enable_n,
    input wire logic [31:0] mem_write_data,
    input wire logic [3:0] mem_clock_out,
    output logic [31:0] mem_read_data,
    output logic ext_wait,
    output logic burst_wait_n,
    output logic mem_feedback_clock
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] mem [16];
    logic [31:0] last;
    logic rd;
    initial begin
        foreach (mem[i]) mem[i] = 32'h0000_0000;
        last = 32'h0000_0000;
    end
    assign rd = !mem_output_enable_n && (bank_select_n != 8'hFF);
    // released bus shows the inverse of the last driven word
    assign mem_read_data = rd ? mem[mem_address[3:0]] : ~last;
    always @(posedge mem_clk) begin
        if (rd) begin
            last <= mem[mem_address[3:0]];
        end
        // store only the selected byte lanes
        if (!mem_write_enable_n && bank_select_n != 8'hFF) begin
            for (int i = 0; i < 4; i++) begin
                if (!byte_lane_select_n[i]) begin
                    mem[mem_address[3:0]][8*i+:8] <= mem_write_data[8*i+:8];
                end
            end
        end
    end
    assign ext_wait = !stall;
    assign burst_wait_n = !stall;
    assign mem_feedback_clock = mem_clock_out[0];
endmodule
`default_nettype wire

// ===== verif/smp_pad_if_asserts.sv
`default_nettype none
module smp_pad_if_asserts (
    input wire logic mem_clk,
    input wire logic presetn,
    input wire logic [7:0] bank_select_n,
    input wire logic [3:0] data_lane_drive_n,
    input wire logic mem_output_enable_n,
    input wire logic mem_write_enable_n,
    input wire logic address_valid,
    input wire logic burst_address_advance,
    input wire logic [3:0] mem_clock_out,
    input wire logic cancel_wait,
    input wire logic ext_wait
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge mem_clk); endclocking
    default disable iff (!presetn);
    sequence seq_stuck;
        (!ext_wait && cancel_wait)[*4];
    endsequence
    sequence seq_idle;
        bank_select_n == 8'hFF && mem_output_enable_n && mem_write_enable_n;
    endsequence
    AST_OE_WE_EXCL: assert property (!(!mem_output_enable_n && !mem_write_enable_n))
        else $error("read and write enables low together");
    AST_ONE_BANK: assert property ($onehot0(~bank_select_n))
        else $error("more than one bank selected");
    AST_DRIVE_WRITE: assert property (data_lane_drive_n != 4'hF |->
        !mem_write_enable_n)
        else $error("data lanes driven outside a write");
    AST_LANE_IDLE: assert property (bank_select_n == 8'hFF |->
        data_lane_drive_n == 4'hF)
        else $error("data lanes driven with no bank selected");
    AST_OE_AFTER_CS: assert property ($fell(mem_output_enable_n) |->
        $past(bank_select_n) != 8'hFF)
        else $error("read enable before chip select");
    AST_AV_PULSE: assert property (address_valid |=> !address_valid)
        else $error("address valid longer than one cycle");
    AST_BAA_PULSE: assert property (burst_address_advance |=> !burst_address_advance)
        else $error("burst advance longer than one cycle");
    AST_CLK_SAME: assert property (mem_clock_out == 4'h0 || mem_clock_out == 4'hF)
        else $error("memory clock outputs differ");
    AST_CANCEL: assert property (seq_stuck |-> ##[0:6] seq_idle)
        else $error("cancel did not end the waited access");
endmodule
bind smp_pad_if smp_pad_if_asserts u_smp_pad_if_asserts (
    .mem_clk(mem_clk),
    .presetn(presetn),
    .bank_select_n(bank_select_n),
    .data_lane_drive_n(data_lane_drive_n),
    .mem_output_enable_n(mem_output_enable_n),
    .mem_write_enable_n(mem_write_enable_n),
    .address_valid(address_valid),
    .burst_address_advance(burst_address_advance),
    .mem_clock_out(mem_clock_out),
    .cancel_wait(cancel_wait),
    .ext_wait(ext_wait)
);
`default_nettype wire

// ===== verif/static_memory_pad_interface_bench.sv
`default_nettype none
module static_memory_pad_interface_bench;
    import smp_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, mem_read_data, mem_write_data;
    logic pready, pslverr, lane_pol = 0, mem_clk = 0, cancel_wait = 0, stall = 0, big_end = 0;
    logic [1:0] width = 2'h0;
    logic ext_wait, burst_wait_n, fb_clk, oe_n, we_n, av, baa;
    logic [25:0] mem_address;
    logic [7:0] bank_select_n;
    logic [3:0] lsel_n, drive_n, mclk;
    logic [31:0] rd;
    logic err;
    int n_errors = 0, n_checks = 0, cyc = 0, n_baa = 0, n_av = 0;
    always #20 pclk = ~pclk;
    always #6 mem_clk = ~mem_clk;
    // counts link pulses for the burst scenario
    always @(posedge mem_clk) begin
        if (baa === 1'b1) n_baa++;
        if (av === 1'b1) n_av++;
    end
    smp_pad_if u_smp_pad_if (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .boot_lane_select_polarity(lane_pol), .boot_bank_width(width),
        .mem_clk(mem_clk), .mem_clock_ratio(2'h1), .big_endian_select(big_end),
        .ext_wait(ext_wait), .burst_wait_n(burst_wait_n), .cancel_wait(cancel_wait),
        .mem_feedback_clock(fb_clk), .mem_read_data(mem_read_data),
        .mem_write_data(mem_write_data), .mem_address(mem_address),
        .bank_select_n(bank_select_n), .byte_lane_select_n(lsel_n),
        .data_lane_drive_n(drive_n), .mem_output_enable_n(oe_n), .mem_write_enable_n(we_n),
        .address_valid(av), .burst_address_advance(baa), .mem_clock_out(mclk));
    smp_mem_model u_smp_mem_model (.mem_clk(mem_clk), .stall(stall), .mem_address(mem_address),
        .bank_select_n(bank_select_n), .byte_lane_select_n(lsel_n),
        .mem_output_enable_n(oe_n), .mem_write_enable_n(we_n), .mem_write_data(mem_write_data),
        .mem_clock_out(mclk), .mem_read_data(mem_read_data), .ext_wait(ext_wait),
        .burst_wait_n(burst_wait_n), .mem_feedback_clock(fb_clk));
    task automatic test_done();
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_errors++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // ------------------------------------------------------------
    // apb master and helpers
    // ------------------------------------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic do_reset(input logic pol, input logic [1:0] w);
        @(posedge pclk);
        presetn <= 0;
        lane_pol <= pol;
        width <= w;
        repeat (5) @(posedge pclk);
        presetn <= 1;
        repeat (4) @(posedge pclk);
    endtask
    task automatic wait_idle();
        rd = 32'h1;
        for (int i = 0; i < 200 && rd[ST_BUSY] !== 1'b0; i++) apb(0, OFS_STATUS, 0);
        chk(rd[ST_BUSY], 1'b0);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_straps();
        for (int w = 0; w < 3; w++) begin
            do_reset(w[0], w[1:0]);
            apb(0, OFS_BANK_CFG0 + 8'h1C, 0);
            chk(rd, {25'h0, w[0], w[1:0], 4'h0});
        end
    endtask
    task automatic access(input logic [7:0] cmd, input logic [31:0] wd);
        apb(1, OFS_ADDR, 32'h0000_0005);
        apb(1, OFS_WDATA, wd);
        apb(1, OFS_CMD, {24'h0, cmd});
        wait_idle();
    endtask
    task automatic t_write_read();
        apb(1, OFS_BANK_CFG0, 32'h0000_0020);
        access(8'hF8, 32'hA5A5_1234);
        chk(mem_write_data, 32'hA5A5_1234);
        chk({6'h0, mem_address}, 32'h0000_0005);
        access(8'hF0, 32'h0);
        apb(0, OFS_RDATA, 0);
        chk(rd, 32'hA5A5_1234);
    endtask
    task automatic t_lanes();
        apb(1, OFS_BANK_CFG0, 32'h0000_0000);
        access(8'hF8, 32'h0000_0000);
        apb(1, OFS_BANK_CFG0, 32'h0000_0020);
        access(8'hF0, 32'h0);
        apb(0, OFS_RDATA, 0);
        chk(rd, 32'hA5A5_1200);
    endtask
    task automatic t_endian();
        big_end <= 1;
        access(8'hF8, 32'h1122_3344);
        chk(mem_write_data, 32'h4433_2211);
        apb(0, OFS_STATUS, 0);
        chk(rd[3:2], 2'h3);
        access(8'hF0, 32'h0);
        apb(0, OFS_RDATA, 0);
        chk(rd, 32'h1122_3344);
        big_end <= 0;
    endtask
    task automatic t_burst();
        apb(1, OFS_BANK_CFG0, 32'h0001_0028);
        stall <= 1;
        apb(1, OFS_CMD, 32'h0000_02F0);
        repeat (20) @(posedge pclk);
        chk(n_baa, 0);
        stall <= 0;
        wait_idle();
        chk(n_baa, 2);
        chk(n_av, 1);
    endtask
    task automatic t_cancel();
        apb(1, OFS_BANK_CFG0 + 8'h04, 32'h0000_0022);
        stall <= 1;
        apb(1, OFS_CMD, 32'h0000_00F1);
        repeat (20) @(posedge pclk);
        chk(bank_select_n, 8'hFD);
        chk({drive_n, oe_n, we_n, lsel_n}, 10'h3D0);
        cancel_wait <= 1;
        wait_idle();
        apb(0, OFS_STATUS, 0);
        chk(rd[1:0], 2'h2);
        chk({bank_select_n, oe_n, we_n}, 10'h3FF);
        cancel_wait <= 0;
        stall <= 0;
    endtask
    task automatic t_unmapped();
        apb(0, 8'h34, 0);
        chk(err, 1'b1);
        apb(0, OFS_STATUS, 0);
        chk(err, 1'b0);
    endtask
    initial begin
        t_straps();
        t_write_read();
        t_lanes();
        t_endian();
        t_burst();
        t_cancel();
        t_unmapped();
        test_done();
    end
endmodule
`default_nettype wire
